// ---- src/cpdrc_top.sv ----
// Power-down, standby, power-up reset, verify lock and programming protection.
// Assumes configuration bits are static; pins and supply comparators are asynchronous.
//
// Overview of operation
// R01: With power-down enabled, either sleep request pin high enters power down.
// R02: Entering power down latches internal signals and enabled output values.
// R03: While powered down, pin changes other than the sleep pin are ignored.
// R04: An output in high impedance at power-down onset stays high impedance.
// R05: Input hold latches stay active during power down so pins never float.
// R06: With power-down enabled, sleep pins are not usable as logic inputs.
// R07: Automatic standby when no transitions occur; leave it when activity resumes.
// R08: Each pin slice has a reduced-power setting adding one cycle delay.
// R09: Power-reset option on trips at 2.8V both ways; off trips down at 0.7V.
// R10: Shortly after supply crosses the trip level, all registers clear low.
// R11: Board logic meets setup times before the first clock high after reset.
// R12: Board logic keeps clocks free of edges during the power-on reset interval; the bench clock runs on and porCnt_r counts its edges.
// R13: With the security fuse set, pattern readback is refused; signature, ID remain.
// R14: Interrupted programming locks the device with all pins high impedance.
// R15: With the keeper on, pins hold their previous level during programming.
// R16: The test port controller is reset automatically at power up.
// R17: With the keeper on, a pin left undriven holds its last driven level.
// R18: When the sleep pin returns low, operation resumes from latched state.
// R19: With power-down disabled, sleep pins are ordinary logic pins.
`timescale 1ns/100ps

module cpdrc_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Static configuration.
    input wire cpdrc_pkg::cpdrc_cfg_t cfg,
    input wire logic [cpdrc_pkg::NPINS-1:0] reducedPower,
    // Sleep request pins and supply comparators.
    input wire logic sleep_request_a,
    input wire logic sleep_request_b,
    input wire logic supplyAbove2v8,
    input wire logic supplyAbove0v7,
    // General pins.
    input wire logic [cpdrc_pkg::NPINS-1:0] padIn,
    input wire logic [cpdrc_pkg::NPINS-1:0] padDriven,
    output logic [cpdrc_pkg::NPINS-1:0] padOut,
    output logic [cpdrc_pkg::NPINS-1:0] padOe,
    // Core logic side.
    input wire logic [cpdrc_pkg::NPINS-1:0] coreOut,
    input wire logic [cpdrc_pkg::NPINS-1:0] coreOe,
    output logic [cpdrc_pkg::NPINS-1:0] coreIn,
    output logic sleepPinLogicA,
    output logic sleepPinLogicB,
    // Programming port.
    input wire logic ispActive,
    input wire logic ispDone,
    input wire logic readReq,
    input wire cpdrc_pkg::cpdrc_rdsel_t readSel,
    input wire logic [15:0] cfgPattern,
    input wire logic [15:0] userSignature,
    output logic readValid,
    output logic readDenied,
    output logic [15:0] readData,
    // Status.
    output logic sleeping,
    output logic standby,
    output logic locked,
    output logic coreClear,
    output logic tapReset
);

    // ****************************************
    // Asynchronous input synchronisers
    // ****************************************
    typedef enum {ST_RUN, ST_SLEEP, ST_PROG, ST_LOCK} cpdrc_state_t;

    logic [3:0] s1_r;
    logic [3:0] s2_r;
    logic [3:0] s3_r;
    logic [3:0] stable_r;

    // Bit order: sleep a, sleep b, high comparator, low comparator.
    wire [3:0] rawAsync = {supplyAbove0v7, supplyAbove2v8, sleep_request_b, sleep_request_a};
    wire [3:0] agree = ~(s2_r ^ s3_r);
    wire [3:0] stableNxt = (agree & s3_r) | (~agree & stable_r);

    // Three flops; a change counts once stages two and three agree.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            s1_r <= 4'h0;
            s2_r <= 4'h0;
            s3_r <= 4'h0;
            stable_r <= 4'h0;
        end
        else
        begin
            s1_r <= rawAsync;
            s2_r <= s1_r;
            s3_r <= s2_r;
            stable_r <= stableNxt;
        end
    end

    // ****************************************
    // Supply trip and power-up reset
    // ****************************************
    logic supplyOk_r;
    logic [cpdrc_pkg::CNT_W-1:0] porCnt_r;
    logic coreClear_r;
    logic tapReset_r;

    // Rising always needs the high level; falling uses the low level with the option off.
    wire tripKeep = cfg.powerResetOn ? stable_r[2] : stable_r[3]; // R09
    wire supplyOkNxt = supplyOk_r ? tripKeep : stable_r[2]; // R09
    wire porDone = porCnt_r == cpdrc_pkg::CNT_W'(cpdrc_pkg::POR_DELAY_CYC);
    wire [cpdrc_pkg::CNT_W-1:0] porCntNxt =
        !supplyOk_r ? '0 : porDone ? porCnt_r : porCnt_r + 1'b1;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            supplyOk_r <= 1'b0;
            porCnt_r <= '0;
            coreClear_r <= 1'b1;
            tapReset_r <= 1'b1;
        end
        else
        begin
            supplyOk_r <= supplyOkNxt;
            porCnt_r <= porCntNxt;
            coreClear_r <= !(supplyOk_r && porDone); // R10
            tapReset_r <= !(supplyOk_r && porDone); // R16
        end
    end

    // ****************************************
    // Mode control
    // ****************************************
    cpdrc_state_t state_r;
    cpdrc_state_t state_nxt;
    logic sleeping_r;
    logic locked_r;

    wire sleepReq = cfg.pdEnable && (stable_r[0] || stable_r[1]); // R01 R19

    // Leaving power down returns straight to run with nothing reset.
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_RUN:
                if (ispActive)
                    state_nxt = ST_PROG;
                else if (sleepReq)
                    state_nxt = ST_SLEEP; // R01
            ST_SLEEP:
                if (!sleepReq)
                    state_nxt = ST_RUN; // R18
            ST_PROG:
                if (!ispActive)
                    state_nxt = ispDone ? ST_RUN : ST_LOCK; // R14
            ST_LOCK:
                if (ispActive)
                    state_nxt = ST_PROG;
            default:
                state_nxt = ST_RUN;
        endcase
    end

    // Status flops take the next state, so they track the state decode cycle for cycle.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state_r <= ST_RUN;
            sleeping_r <= 1'b0;
            locked_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            sleeping_r <= state_nxt == ST_SLEEP; // R01
            locked_r <= state_nxt == ST_LOCK; // R14
        end
    end

    wire freeze = state_r == ST_SLEEP; // R02 R03
    wire lock = state_r == ST_LOCK; // R14
    wire prog = state_r == ST_PROG;

    // ****************************************
    // Pin slices
    // ****************************************
    logic [cpdrc_pkg::NPINS-1:0] pinAct;

    for (genvar i = 0; i < cpdrc_pkg::NPINS; i++)
    begin : g_pin
        cpdrc_pin_cell u_cell (
            .clk(clk),
            .nrst(nrst),
            .padIn(padIn[i]),
            .padDriven(padDriven[i]),
            .padOut(padOut[i]),
            .padOe(padOe[i]),
            .coreOut(coreOut[i]),
            .coreOe(coreOe[i]),
            .coreIn(coreIn[i]),
            .activity(pinAct[i]),
            .freeze(freeze),
            .lock(lock),
            .prog(prog),
            .keep(cfg.keeperEnable),
            .slow(reducedPower[i])
        );
    end

    // ****************************************
    // Sleep pin logic use and standby
    // ****************************************
    logic sleepA_r;
    logic sleepB_r;
    logic [cpdrc_pkg::NPINS-1:0] coreOutPrev_r;
    logic [cpdrc_pkg::CNT_W-1:0] idleCnt_r;
    logic standby_r;

    // A general pin level change or a coreOut change counts as activity and wakes the device.
    wire anyAct = (|pinAct) || (coreOut != coreOutPrev_r);
    wire idleFull = idleCnt_r == cpdrc_pkg::CNT_W'(cpdrc_pkg::IDLE_CYC);
    wire [cpdrc_pkg::CNT_W-1:0] idleNxt =
        (anyAct || state_r != ST_RUN) ? '0 : idleFull ? idleCnt_r : idleCnt_r + 1'b1;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            sleepA_r <= 1'b0;
            sleepB_r <= 1'b0;
            coreOutPrev_r <= '0;
            idleCnt_r <= '0;
            standby_r <= 1'b0;
        end
        else
        begin
            sleepA_r <= cfg.pdEnable ? 1'b0 : stable_r[0]; // R06 R19
            sleepB_r <= cfg.pdEnable ? 1'b0 : stable_r[1]; // R06 R19
            coreOutPrev_r <= coreOut;
            idleCnt_r <= idleNxt;
            standby_r <= idleFull && !anyAct && state_r == ST_RUN; // R07
        end
    end

    // ****************************************
    // Readback with verify lock
    // ****************************************
    logic readValid_r;
    logic readDenied_r;
    logic [15:0] readData_r;

    // The fuse blocks only the pattern; signature and identity stay readable.
    wire deny = readSel == cpdrc_pkg::RD_PATTERN && cfg.securityFuse; // R13
    wire [15:0] rdMux = deny ? 16'h0000 :
        readSel == cpdrc_pkg::RD_PATTERN ? cfgPattern :
        readSel == cpdrc_pkg::RD_SIGNATURE ? userSignature :
        readSel == cpdrc_pkg::RD_DEVID ? cpdrc_pkg::DEVICE_ID : 16'h0000;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            readValid_r <= 1'b0;
            readDenied_r <= 1'b0;
            readData_r <= cpdrc_pkg::SIG_RESET;
        end
        else
        begin
            readValid_r <= readReq && !deny;
            readDenied_r <= readReq && deny; // R13
            readData_r <= readReq ? rdMux : readData_r;
        end
    end

    assign sleepPinLogicA = sleepA_r;
    assign sleepPinLogicB = sleepB_r;
    assign readValid = readValid_r;
    assign readDenied = readDenied_r;
    assign readData = readData_r;
    assign sleeping = sleeping_r;
    assign standby = standby_r;
    assign locked = locked_r;
    assign coreClear = coreClear_r;
    assign tapReset = tapReset_r;

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_sleep_entry: assert property (state_r == ST_RUN && !ispActive && sleepReq |=> sleeping) // R01
        else $error("sleep request did not enter power down");
    a_hold_outputs: assert property (sleeping && $past(sleeping) |=> $stable(padOut) && $stable(padOe)) // R02
        else $error("outputs changed while powered down");
    a_freeze_inputs: assert property (sleeping ##1 sleeping |=> $stable(coreIn)) // R03
        else $error("core inputs changed while powered down");
    a_hiz_kept: assert property (sleeping |=> (padOe & ~$past(padOe)) == '0) // R04
        else $error("high impedance output was enabled in power down");
    a_pin_unused: assert property (cfg.pdEnable |=> !sleepPinLogicA && !sleepPinLogicB) // R06
        else $error("sleep pin leaked as logic input");
    a_wake_resume: assert property (sleeping && !sleepReq |=> state_r == ST_RUN && !coreClear) // R18
        else $error("did not resume after sleep pin went low");
    a_fuse_denies: assert property (readReq && readSel == cpdrc_pkg::RD_PATTERN && cfg.securityFuse
        |=> readDenied && !readValid) // R13
        else $error("pattern read while fuse set");
    a_id_readable: assert property (readReq && readSel == cpdrc_pkg::RD_DEVID
        |=> readValid && readData == cpdrc_pkg::DEVICE_ID) // R13
        else $error("identity read failed");
    a_lock_hiz: assert property (prog && !ispActive && !ispDone ##1 1'b1 |=> padOe == '0) // R14
        else $error("pins driven after interrupted programming");
    a_clear_low_supply: assert property (!supplyOk_r |=> coreClear && tapReset) // R10
        else $error("registers not held clear with supply low");
    a_standby_wake: assert property (standby && anyAct |=> !standby) // R07
        else $error("standby kept despite activity");

    c_sleep_cycle: cover property (sleeping ##[1:20] !sleeping);
    c_lock_seen: cover property (locked);
    c_standby_seen: cover property (standby);

endmodule // cpdrc_top

// ---- src/cpdrc_pkg.sv ----
// Constants and carrier types shared by the power-down and reset controller.
// Assumes a single 50 MHz clock and plain configuration ports, with no register bus.
package cpdrc_pkg;

    // ****************************************
    // Sizes and timing
    // ****************************************
    localparam int NPINS = 8;
    localparam int CLK_PERIOD_NS = 20;
    // Delay from the supply trip until registers are released.
    localparam int POR_DELAY_NS = 200;
    localparam int POR_DELAY_CYC = (POR_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Quiet time before the automatic standby state is entered.
    localparam int IDLE_NS = 1000;
    localparam int IDLE_CYC = IDLE_NS / CLK_PERIOD_NS;
    localparam int CNT_W = 8;
    // Device identity and read data reset value; both values are arbitrary.
    localparam logic [15:0] DEVICE_ID = 16'h5A3C;
    localparam logic [15:0] SIG_RESET = 16'h0000;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {RD_PATTERN, RD_SIGNATURE, RD_DEVID, RD_NONE} cpdrc_rdsel_t;

    typedef struct packed {
        logic pdEnable;
        logic powerResetOn;
        logic keeperEnable;
        logic securityFuse;
    } cpdrc_cfg_t;

endpackage

// ---- src/cpdrc_pin_cell.sv ----
// One pin slice: input synchroniser, keeper, hold latches and output hold.
// Assumes padIn and padDriven are asynchronous pins; the rest come from the same clock.
`timescale 1ns/100ps

module cpdrc_pin_cell (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // Pin side.
    input wire logic padIn,
    input wire logic padDriven,
    output logic padOut,
    output logic padOe,
    // Core side.
    input wire logic coreOut,
    input wire logic coreOe,
    output logic coreIn,
    output logic activity,
    // Control.
    input wire logic freeze,
    input wire logic lock,
    input wire logic prog,
    input wire logic keep,
    input wire logic slow
);

    // ****************************************
    // Synchronisers
    // ****************************************
    logic [2:0] inSync_r;
    logic [2:0] drvSync_r;
    logic level_r;
    logic slowLevel_r;
    logic coreIn_r;
    logic act_r;
    logic padOut_r;
    logic padOe_r;

    // Three stages each; only stages two and three are ever compared.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            inSync_r <= 3'h0;
            drvSync_r <= 3'h0;
        end
        else
        begin
            inSync_r <= {inSync_r[1:0], padIn};
            drvSync_r <= {drvSync_r[1:0], padDriven};
        end
    end

    wire inAgree = inSync_r[1] == inSync_r[2];
    wire driven = drvSync_r[1] & drvSync_r[2];
    // An undriven pin keeps its last level when the keeper is on.
    wire takeLevel = inAgree && (driven || !keep); // R17
    wire levelNxt = takeLevel ? inSync_r[2] : level_r;
    // The reduced-power path costs one extra cycle of latency.
    wire srcLevel = slow ? slowLevel_r : level_r; // R08

    // ****************************************
    // Input hold and activity
    // ****************************************
    // A frozen cell ignores pin changes so the core sees the held value.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            level_r <= 1'b0;
            slowLevel_r <= 1'b0;
            coreIn_r <= 1'b0;
            act_r <= 1'b0;
        end
        else
        begin
            level_r <= levelNxt; // R05
            slowLevel_r <= level_r;
            coreIn_r <= freeze ? coreIn_r : srcLevel; // R03
            act_r <= levelNxt != level_r;
        end
    end

    // ****************************************
    // Output hold, lock and keeper
    // ****************************************
    wire padOeNxt = lock ? 1'b0 : prog ? keep : freeze ? padOe_r : coreOe; // R14 R15 R04
    wire padOutNxt = lock ? padOut_r : prog ? level_r : freeze ? padOut_r : coreOut; // R02

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            padOut_r <= 1'b0;
            padOe_r <= 1'b0;
        end
        else
        begin
            padOut_r <= padOutNxt;
            padOe_r <= padOeNxt;
        end
    end

    assign padOut = padOut_r;
    assign padOe = padOe_r;
    assign coreIn = coreIn_r;
    assign activity = act_r;

endmodule // cpdrc_pin_cell

// ---- tb/cpdrc_board_model.sv ----
// Board-side model: sleep request pins, supply comparators and pin drivers.
// Assumes callers change its outputs just after a rising clock edge.
`timescale 1ns/100ps

module cpdrc_board_model (
    // Sleep request pins.
    output logic sleepA,
    output logic sleepB,
    // Supply comparators.
    output logic above2v8,
    output logic above0v7,
    // General pins.
    output logic [cpdrc_pkg::NPINS-1:0] padIn,
    output logic [cpdrc_pkg::NPINS-1:0] padDriven
);
    // The supply starts low and the pins start driven low, so nothing moves during power up.
    initial
    begin
        sleepA = 1'h0;
        sleepB = 1'h0;
        above2v8 = 1'h0;
        above0v7 = 1'h0;
        padDriven = '1;
        padIn = '0;
    end

    // A released pin shows the inverse of its last level, so a missing keeper is seen.
    task automatic setPads(input logic [cpdrc_pkg::NPINS-1:0] v,
                           input logic [cpdrc_pkg::NPINS-1:0] drv);
        padDriven = drv;
        padIn = ~(v ^ drv);
    endtask

    // Changes come only after an edge, which keeps setup times met.
    task automatic setSleep(input logic a, input logic b);
        sleepA = a;
        sleepB = b;
    endtask

    // Supply is raised only while reset holds the core, with no pin edges meanwhile.
    task automatic setSupply(input logic h, input logic l);
        above2v8 = h;
        above0v7 = l;
    endtask
endmodule // cpdrc_board_model

// ---- tb/cpdrc_top_tb.sv ----
// Self-checking bench for the power-down and reset controller.
// Assumes the board model drives pins and supply; all other inputs are driven here.
`timescale 1ns/100ps

module cpdrc_top_tb;
    // ****************************************
    // Signals
    // ****************************************
    logic clk, nrst, ispActive, ispDone, readReq, readValid, readDenied;
    logic sleepA, sleepB, hi, lo, pinA, pinB, sleeping, standby, locked, coreClear, tapReset;
    cpdrc_pkg::cpdrc_cfg_t cfg;
    cpdrc_pkg::cpdrc_rdsel_t readSel;
    logic [cpdrc_pkg::NPINS-1:0] rp, padIn, padDriven, padOut, padOe, coreOut, coreOe, coreIn;
    logic [15:0] readData;
    int fails, checked, n;

    cpdrc_board_model u_board (.sleepA(sleepA), .sleepB(sleepB), .above2v8(hi),
        .above0v7(lo), .padIn(padIn), .padDriven(padDriven));

    cpdrc_top u_dut (.clk(clk), .nrst(nrst), .cfg(cfg), .reducedPower(rp),
        .sleep_request_a(sleepA), .sleep_request_b(sleepB), .supplyAbove2v8(hi),
        .supplyAbove0v7(lo), .padIn(padIn), .padDriven(padDriven), .padOut(padOut),
        .padOe(padOe), .coreOut(coreOut), .coreOe(coreOe), .coreIn(coreIn),
        .sleepPinLogicA(pinA), .sleepPinLogicB(pinB), .ispActive(ispActive),
        .ispDone(ispDone), .readReq(readReq), .readSel(readSel), .cfgPattern(16'hC3A5),
        .userSignature(16'h1E2D), .readValid(readValid), .readDenied(readDenied),
        .readData(readData), .sleeping(sleeping), .standby(standby), .locked(locked),
        .coreClear(coreClear), .tapReset(tapReset));

    // 50 MHz clock.
    initial
    begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    // ****************************************
    // Tasks
    // ****************************************
    // Inputs always move 1 ns after the edge, so no race with the design's flops.
    task automatic tick(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Bounded wait; running out leaves the final compare to count the mismatch.
    task automatic waitFor(input string what, ref logic sig, input logic val, input int lim);
        n = 0;
        while (sig !== val && n < lim)
        begin
            tick(1);
            n++;
        end
        chk(what, {15'h0000, val}, {15'h0000, sig});
        // A wait that ran out ends the run at once.
        if (sig !== val)
            stop_test();
    endtask

    task automatic rd(input cpdrc_pkg::cpdrc_rdsel_t s, input logic den, input logic [15:0] exp);
        readReq = 1'h1;
        readSel = s;
        tick(1);
        readReq = 1'h0;
        // The valid and denied flags stand for one cycle only, so they are taken right after the request edge.
        chk("readValid", {15'h0000, ~den}, {15'h0000, readValid});
        chk("readDenied", {15'h0000, den}, {15'h0000, readDenied});
        chk("readData", exp, readData);
        tick(1);
        chk("readValid", 16'h0000, {15'h0000, readValid});
    endtask

    // Configuration only changes under reset, since it is static to the design.
    task automatic doReset(input cpdrc_pkg::cpdrc_cfg_t c);
        nrst = 1'h0;
        cfg = c;
        u_board.setSupply(1'h1, 1'h1);
        tick(8);
        chk("coreClear", 16'h0001, {15'h0000, coreClear});
        chk("tapReset", 16'h0001, {15'h0000, tapReset});
        nrst = 1'h1;
        waitFor("coreClear", coreClear, 1'h0, 40);
        chk("tapReset", 16'h0000, {15'h0000, tapReset});
    endtask

    task automatic stop_test;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        {nrst, ispActive, ispDone, readReq} = 4'h0;
        readSel = cpdrc_pkg::RD_NONE;
        cfg = 4'h0;
        rp = 8'h0F;
        coreOut = 8'hA5;
        coreOe = 8'hF0;
        fails = 0;
        checked = 0;
        tick(1);
        // Phase one: power down on, power reset on, keeper on, fuse clear.
        doReset(4'hE);
        u_board.setPads(8'h3C, 8'hFF);
        tick(5);
        chk("coreIn", 16'h0030, {8'h00, coreIn});
        tick(1);
        chk("coreIn", 16'h003C, {8'h00, coreIn});
        chk("padOe", 16'h00F0, {8'h00, padOe});
        chk("padOut", 16'h00A0, {8'h00, padOut & 8'hF0});
        u_board.setPads(8'h3C, 8'h00);
        tick(6);
        chk("coreIn", 16'h003C, {8'h00, coreIn});
        u_board.setPads(8'h3C, 8'hFF);
        tick(cpdrc_pkg::IDLE_CYC + 4);
        chk("standby", 16'h0001, {15'h0000, standby});
        u_board.setPads(8'h55, 8'hFF);
        waitFor("standby", standby, 1'h0, 8);
        tick(6);
        // Sleep through each request pin in turn; the pins and core move while asleep.
        for (int p = 0; p < 2; p++)
        begin
            u_board.setSleep(p == 0, p == 1);
            waitFor("sleeping", sleeping, 1'h1, 8);
            chk("sleepPinLogic", 16'h0000, {14'h0000, pinA, pinB});
            u_board.setPads(8'hAA, 8'hFF);
            coreOut = 8'h0F;
            coreOe = 8'hFF;
            tick(8);
            chk("coreIn", 16'h0055, {8'h00, coreIn});
            chk("padOe", 16'h00F0, {8'h00, padOe});
            chk("padOut", 16'h00A0, {8'h00, padOut & 8'hF0});
            u_board.setSleep(1'h0, 1'h0);
            waitFor("sleeping", sleeping, 1'h0, 8);
            tick(6);
            chk("coreIn", 16'h00AA, {8'h00, coreIn});
            chk("padOut", 16'h000F, {8'h00, padOut});
            u_board.setPads(8'h55, 8'hFF);
            coreOut = 8'hA5;
            coreOe = 8'hF0;
            tick(8);
        end
        // Interrupted programming, then a completed one that clears the lock.
        ispActive = 1'h1;
        tick(3);
        chk("padOe", 16'h00FF, {8'h00, padOe});
        chk("padOut", 16'h0055, {8'h00, padOut});
        ispActive = 1'h0;
        tick(3);
        chk("locked", 16'h0001, {15'h0000, locked});
        chk("padOe", 16'h0000, {8'h00, padOe});
        ispActive = 1'h1;
        ispDone = 1'h1;
        tick(3);
        ispActive = 1'h0;
        tick(3);
        chk("locked", 16'h0000, {15'h0000, locked});
        rd(cpdrc_pkg::RD_PATTERN, 1'h0, 16'hC3A5);
        rd(cpdrc_pkg::RD_SIGNATURE, 1'h0, 16'h1E2D);
        rd(cpdrc_pkg::RD_DEVID, 1'h0, cpdrc_pkg::DEVICE_ID);
        u_board.setSupply(1'h0, 1'h1);
        waitFor("coreClear", coreClear, 1'h1, 8);
        // Phase two: power down off, power reset off, keeper on, fuse set.
        doReset(4'h3);
        rd(cpdrc_pkg::RD_PATTERN, 1'h1, 16'h0000);
        rd(cpdrc_pkg::RD_SIGNATURE, 1'h0, 16'h1E2D);
        rd(cpdrc_pkg::RD_DEVID, 1'h0, cpdrc_pkg::DEVICE_ID);
        u_board.setSleep(1'h1, 1'h1);
        tick(6);
        chk("sleeping", 16'h0000, {15'h0000, sleeping});
        chk("sleepPinLogic", 16'h0003, {14'h0000, pinA, pinB});
        u_board.setSleep(1'h0, 1'h0);
        u_board.setSupply(1'h0, 1'h1);
        tick(8);
        chk("coreClear", 16'h0000, {15'h0000, coreClear});
        u_board.setSupply(1'h0, 1'h0);
        waitFor("coreClear", coreClear, 1'h1, 8);
        stop_test();
    end
endmodule // cpdrc_top_tb
